// file: flash_command_sequencer.sv
// Purpose: flash program/erase sequencer with APB registers
// Assumes: array answers each request with a one-cycle done pulse
// Notes: error address holds the high half of the failing start address
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps
module flash_command_sequencer #(
  parameter logic [31:0] UID0 = 32'h1234_0000, // Arbitrary value
  parameter logic [31:0] UID1 = 32'h1234_0001, // Arbitrary value
  parameter logic [31:0] UID2 = 32'h1234_0002, // Arbitrary value
  parameter logic [31:0] UID3 = 32'h1234_0003, // Arbitrary value
  parameter logic [31:0] USER_BASE = flash_seq_pkg::USER_BASE_256K // [R15]
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash array
  output flash_seq_pkg::array_req_t array_req,
  input wire logic array_done,
  input wire logic array_fail,
  // Fetch side and status
  output logic fetch_allowed,
  output logic [3:0] code_wait,
  output logic [3:0] data_wait,
  // Programmer ID check
  input wire logic id_match,
  output logic programmer_ok,
  // Interrupt
  output logic flash_ready_irq
);
  typedef struct packed {
    logic [1:0] mode;
    logic [31:0] saddr;
    logic [31:0] eaddr;
    logic [15:0] err_hi;
    logic [3:0][31:0] wbuf;
    logic prot;
    logic startup_swap;
    logic [3:0] cw;
    logic [3:0] dw;
    logic [2:0] ist;
    logic [2:0] imask;
    logic [31:0] win_s;
    logic [31:0] win_e;
    flash_seq_pkg::seq_state_t st;
    flash_seq_pkg::array_req_t rq;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic irq;
    logic pok;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic [3:0][31:0] uid;
  logic acc;
  logic wr;
  logic in_win;
  logic startup_blk;
  logic [2:0] ev;

  assign uid = {UID3, UID2, UID1, UID0}; // [R13]
  assign acc = psel & penable & ~s_r.ready;
  assign wr = acc & pwrite;

  // Window test on user blocks
  always_comb begin
    in_win = (s_r.saddr >= s_r.win_s) && (s_r.eaddr <= s_r.win_e); // [R07]
    startup_blk = (s_r.saddr >= USER_BASE) &&
      (16'((s_r.saddr - USER_BASE) >> flash_seq_pkg::BLOCK_SHIFT) <= flash_seq_pkg::STARTUP_LAST_BLOCK); // [R06]
  end

  // Whole next-state calculation
  always_comb begin
    s_nxt = s_r;
    ev = 3'h0;
    s_nxt.ready = acc;
    s_nxt.err = 1'b0;
    s_nxt.rq.req = 1'b0;
    s_nxt.pok = id_match; // [R17]
    // Read mux; unmapped reads zero
    s_nxt.rdata = 32'h0000_0000;
    unique case (paddr)
      flash_seq_pkg::OFF_MODE: s_nxt.rdata = {30'h0, s_r.mode};
      flash_seq_pkg::OFF_SADDR_LO: s_nxt.rdata = {16'h0, s_r.saddr[15:0]};
      flash_seq_pkg::OFF_SADDR_HI: s_nxt.rdata = {16'h0, s_r.saddr[31:16]}; // [R09]
      flash_seq_pkg::OFF_EADDR_LO: s_nxt.rdata = {16'h0, s_r.eaddr[15:0]};
      flash_seq_pkg::OFF_EADDR_HI: s_nxt.rdata = {16'h0, s_r.eaddr[31:16]}; // [R09]
      flash_seq_pkg::OFF_ERR_HI: s_nxt.rdata = {16'h0, s_r.err_hi}; // [R10]
      flash_seq_pkg::OFF_STARTUP_MON: s_nxt.rdata = {30'h0, s_r.startup_swap, s_r.prot}; // [R12]
      flash_seq_pkg::OFF_CODE_WAIT: s_nxt.rdata = {28'h0, s_r.cw}; // [R14]
      flash_seq_pkg::OFF_DATA_WAIT: s_nxt.rdata = {28'h0, s_r.dw}; // [R14]
      flash_seq_pkg::OFF_STATUS: s_nxt.rdata = {30'h0, s_r.st == flash_seq_pkg::SEQ_IDLE,
                                               s_r.st != flash_seq_pkg::SEQ_IDLE};
      flash_seq_pkg::OFF_IRQ_STAT: s_nxt.rdata = {29'h0, s_r.ist};
      flash_seq_pkg::OFF_IRQ_MASK: s_nxt.rdata = {29'h0, s_r.imask};
      flash_seq_pkg::OFF_WIN_START: s_nxt.rdata = s_r.win_s;
      flash_seq_pkg::OFF_WIN_END: s_nxt.rdata = s_r.win_e;
      default: begin
        if (paddr[7:4] == flash_seq_pkg::OFF_WBUF0[7:4]) begin
          s_nxt.rdata = s_r.wbuf[paddr[3:2]]; // [R11]
        end else if (paddr[7:4] == flash_seq_pkg::OFF_UID0[7:4]) begin
          s_nxt.rdata = uid[paddr[3:2]]; // [R13]
        end
      end
    endcase
    if (!acc || pwrite) begin
      s_nxt.rdata = 32'h0000_0000;
    end
    // Register writes; only legal modes are stored
    if (wr) begin
      unique case (paddr)
        flash_seq_pkg::OFF_MODE: begin
          if (pwdata[1:0] != 2'h3) begin
            s_nxt.mode = pwdata[1:0]; // [R01]
          end else begin
            s_nxt.err = 1'b1;
          end
        end
        flash_seq_pkg::OFF_SADDR_LO: s_nxt.saddr[15:0] = pwdata[15:0];
        flash_seq_pkg::OFF_SADDR_HI: s_nxt.saddr[31:16] = pwdata[15:0]; // [R09]
        flash_seq_pkg::OFF_EADDR_LO: s_nxt.eaddr[15:0] = pwdata[15:0];
        flash_seq_pkg::OFF_EADDR_HI: s_nxt.eaddr[31:16] = pwdata[15:0]; // [R09]
        flash_seq_pkg::OFF_CODE_WAIT: s_nxt.cw = pwdata[3:0]; // [R14]
        flash_seq_pkg::OFF_DATA_WAIT: s_nxt.dw = pwdata[3:0]; // [R14]
        flash_seq_pkg::OFF_IRQ_MASK: s_nxt.imask = pwdata[2:0];
        flash_seq_pkg::OFF_IRQ_STAT: s_nxt.ist = s_r.ist & ~pwdata[2:0];
        flash_seq_pkg::OFF_WIN_START: s_nxt.win_s = s_r.prot ? s_r.win_s : pwdata;
        flash_seq_pkg::OFF_WIN_END: s_nxt.win_e = s_r.prot ? s_r.win_e : pwdata;
        flash_seq_pkg::OFF_STOP: begin
          if (s_r.st == flash_seq_pkg::SEQ_BUSY) begin
            s_nxt.st = flash_seq_pkg::SEQ_STOP;
          end
        end
        flash_seq_pkg::OFF_CMD: begin
          // Busy or read mode rejects the command
          if (s_r.st != flash_seq_pkg::SEQ_IDLE || s_r.mode == flash_seq_pkg::MODE_READ) begin
            s_nxt.err = 1'b1; // [R18]
          end else if (!(pwdata[3:0] inside {flash_seq_pkg::CMD_PROGRAM, flash_seq_pkg::CMD_BLANK,
                     flash_seq_pkg::CMD_BLOCK_ERASE, flash_seq_pkg::CMD_ALL_ERASE})) begin
            s_nxt.err = 1'b1; // [R02]
          end else if (s_r.mode == flash_seq_pkg::MODE_CODE_PE && !in_win) begin
            s_nxt.err = 1'b1; // [R07]
          end else if (s_r.mode == flash_seq_pkg::MODE_CODE_PE && startup_blk && !s_r.startup_swap) begin
            s_nxt.err = 1'b1; // [R06]
          end else begin
            s_nxt.rq = '{req: 1'b1, op: pwdata[2:0], addr: s_r.saddr, wdata: s_r.wbuf[0]};
            s_nxt.st = flash_seq_pkg::SEQ_BUSY;
          end
        end
        flash_seq_pkg::OFF_EXCMD: begin
          if (s_r.st != flash_seq_pkg::SEQ_IDLE || s_r.mode != flash_seq_pkg::MODE_CODE_PE) begin
            s_nxt.err = 1'b1; // [R18]
          end else if (pwdata[2:0] == flash_seq_pkg::EXCMD_STARTUP) begin
            s_nxt.startup_swap = pwdata[8]; // [R03]
            s_nxt.prot = s_r.prot | pwdata[9]; // [R12]
            ev[flash_seq_pkg::IRQ_DONE] = 1'b1;
          end else if (pwdata[2:0] == flash_seq_pkg::EXCMD_WINDOW && !s_r.prot) begin
            ev[flash_seq_pkg::IRQ_DONE] = 1'b1; // [R03]
          end else begin
            s_nxt.err = 1'b1; // [R03]
          end
        end
        default: begin
          if (paddr[7:4] == flash_seq_pkg::OFF_WBUF0[7:4]) begin
            s_nxt.wbuf[paddr[3:2]] = pwdata; // [R11]
          end
        end
      endcase
    end
    // Array completion ends the command
    if (s_r.st != flash_seq_pkg::SEQ_IDLE && array_done) begin
      ev[s_r.st == flash_seq_pkg::SEQ_STOP ? flash_seq_pkg::IRQ_STOP_DONE : flash_seq_pkg::IRQ_DONE] = 1'b1; // [R04]
      if (array_fail) begin
        s_nxt.err_hi = s_r.saddr[31:16]; // [R10]
        ev[flash_seq_pkg::IRQ_ERROR] = 1'b1;
      end
      s_nxt.st = flash_seq_pkg::SEQ_IDLE;
    end
    if (s_nxt.err) begin
      ev[flash_seq_pkg::IRQ_ERROR] = 1'b1;
    end
    // Set wins over write-one clear
    s_nxt.ist = s_nxt.ist | ev;
    // A set mask bit hides its status bit
    s_nxt.irq = |(s_nxt.ist & ~s_nxt.imask);
  end

  // Single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{mode: flash_seq_pkg::MODE_READ, cw: flash_seq_pkg::WAIT_RST, dw: flash_seq_pkg::WAIT_RST,
               win_e: flash_seq_pkg::WIN_END_RST, st: flash_seq_pkg::SEQ_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flops
  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.err & s_r.ready;
  assign array_req = s_r.rq;
  // Fetch blocked only in code P/E mode while programmer_ok is low; erased data reads FFh from the array [R05]
  assign fetch_allowed = s_r.pok | (s_r.mode != flash_seq_pkg::MODE_CODE_PE); // [R08]
  assign code_wait = s_r.cw;
  assign data_wait = s_r.dw;
  assign programmer_ok = s_r.pok; // [R17]
  assign flash_ready_irq = s_r.irq;
endmodule

// file: flash_seq_pkg.sv
// Purpose: shared constants and types for the flash command sequencer
// Assumes: APB slave, 32-bit data, one word per register
// Notes: offsets and reset values chosen for this block
// What this block does
// [R01] Mode field: 00 read, 01 code, 10 data
// [R02] Command codes 1,3,4,6 valid; rest prohibited
// [R03] Extra-area commands 001 and 010 only
// [R04] Ready interrupt on command or forced-stop end
// [R05] Erased bytes read back as all ones
// [R06] Start-up protection covers user blocks zero-seven
// [R07] Self-programming limited to access window blocks
// [R08] Code fetches continue during data-flash operation
// [R09] Start and end address high halves 16 bits
// [R10] Error address high half 16 bits
// [R11] Four write buffer words, index 0-3
// [R12] Window protect flag in start-up monitor
// [R13] Unique identifier as four 32-bit words
// [R14] Separate code and data-flash read waits
// [R15] User area ends at top of space
// [R16] User area 256 KB, data area 8 KB
// [R17] Programmer connects only with matching ID
// [R18] Commands only in matching P/E mode
package flash_seq_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_EXCMD = 8'h08;
  localparam logic [7:0] OFF_SADDR_LO = 8'h0C;
  localparam logic [7:0] OFF_SADDR_HI = 8'h10;
  localparam logic [7:0] OFF_EADDR_LO = 8'h14;
  localparam logic [7:0] OFF_EADDR_HI = 8'h18;
  localparam logic [7:0] OFF_ERR_HI = 8'h1C;
  localparam logic [7:0] OFF_WBUF0 = 8'h20;
  localparam logic [7:0] OFF_STARTUP_MON = 8'h30;
  localparam logic [7:0] OFF_CODE_WAIT = 8'h34;
  localparam logic [7:0] OFF_DATA_WAIT = 8'h38;
  localparam logic [7:0] OFF_STATUS = 8'h3C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h40;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h44;
  localparam logic [7:0] OFF_WIN_START = 8'h48;
  localparam logic [7:0] OFF_WIN_END = 8'h4C;
  localparam logic [7:0] OFF_STOP = 8'h50;
  localparam logic [7:0] OFF_UID0 = 8'h60;
  // Encodings
  localparam logic [1:0] MODE_READ = 2'h0;
  localparam logic [1:0] MODE_CODE_PE = 2'h1;
  localparam logic [1:0] MODE_DATA_PE = 2'h2;
  localparam logic [3:0] CMD_PROGRAM = 4'h1;
  localparam logic [3:0] CMD_BLANK = 4'h3;
  localparam logic [3:0] CMD_BLOCK_ERASE = 4'h4;
  localparam logic [3:0] CMD_ALL_ERASE = 4'h6;
  localparam logic [2:0] EXCMD_STARTUP = 3'h1;
  localparam logic [2:0] EXCMD_WINDOW = 3'h2;
  // Address map
  localparam logic [31:0] USER_BASE_256K = 32'hFFFC_0000;
  localparam logic [31:0] USER_BASE_128K = 32'hFFFE_0000;
  localparam logic [31:0] USER_BASE_64K = 32'hFFFF_0000;
  localparam int DATA_AREA_BYTES = 8192;
  localparam int BLOCK_SHIFT = 11;
  localparam logic [15:0] STARTUP_LAST_BLOCK = 16'h0007;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_STOP_DONE = 1;
  localparam int IRQ_ERROR = 2;
  // Reset values
  localparam logic [3:0] WAIT_RST = 4'h0;
  localparam logic [31:0] WIN_END_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] UID_WORD_RST = 32'h0000_0000;
  // Flash array request
  typedef struct packed {
    logic req;
    logic [2:0] op;
    logic [31:0] addr;
    logic [31:0] wdata;
  } array_req_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_BUSY, SEQ_STOP} seq_state_t;
endpackage

// file: flash_seq_properties.sv
// Purpose: port checks for the flash command sequencer
// Assumes: APB answer one cycle into the access phase
// Notes: bound to every instance of the top module
`timescale 1ns/10ps
module flash_seq_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Array and ID
  input flash_seq_pkg::array_req_t array_req,
  input wire logic id_match,
  input wire logic programmer_ok
);
  // Write being taken this cycle
  logic wr;
  assign wr = psel && penable && pwrite && !pready;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
  a_ready_answer: assert property (psel && penable && !pready |=> pready) else $error("late answer");
  a_err_qual: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_req_pulse: assert property (array_req.req |=> !array_req.req) else $error("request not a pulse");
  a_mode_refuse: assert property (wr && paddr == flash_seq_pkg::OFF_MODE && pwdata[1:0] == 2'h3 |=> pslverr)
    else $error("mode 11 accepted");
  a_cmd_refuse: assert property (wr && paddr == flash_seq_pkg::OFF_CMD && !(pwdata[3:0] inside {1, 3, 4, 6})
    |=> pslverr) else $error("bad command accepted");
  a_excmd_refuse: assert property (wr && paddr == flash_seq_pkg::OFF_EXCMD && !(pwdata[2:0] inside {1, 2})
    |=> pslverr) else $error("bad extra command accepted");
  a_id_follow: assert property (id_match [*2] |-> programmer_ok) else $error("programmer refused");
endmodule
bind flash_command_sequencer flash_seq_properties chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .array_req(array_req), .id_match(id_match), .programmer_ok(programmer_ok));

// file: flash_array_model.sv
// Purpose: behavioural flash array for the sequencer bench
// Assumes: one done pulse answers each request
// Notes: fail only means something beside done
`timescale 1ns/10ps
module flash_array_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request side
  input wire logic req,
  input wire logic slow,
  input wire logic fail_cmd,
  output logic done,
  output logic fail
);
  int cnt;
  // Busy count then done; fail toggles outside done so no stale level passes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      done <= 1'b0;
      fail <= 1'b0;
    end else begin
      done <= (cnt == 1);
      fail <= (cnt == 1) ? fail_cmd : ~fail;
      if (req) cnt <= slow ? 24 : 3;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule

// file: tb_top.sv
// Purpose: self-checking bench for the flash command sequencer
// Assumes: mask bit set hides its status bit
// Notes: APB notes queued, checked at the answer
`timescale 1ns/10ps
module tb_top;
  localparam logic [31:0] UIDB = 32'h5EED_0000; // Arbitrary value
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, array_done, array_fail, id_match;
  logic fetch_allowed, programmer_ok, flash_ready_irq, fail_cmd, slow;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0] code_wait, data_wait;
  logic [2:0] last_op;
  logic [33:0] exq[$];
  logic [33:0] e;
  logic [39:0] ops [6];
  flash_seq_pkg::array_req_t array_req;
  int failures, num_checks, seed, i;
  flash_command_sequencer #(.UID0(UIDB), .UID1(UIDB + 1), .UID2(UIDB + 2), .UID3(UIDB + 3)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .array_req(array_req),
    .array_done(array_done), .array_fail(array_fail), .fetch_allowed(fetch_allowed), .code_wait(code_wait),
    .data_wait(data_wait), .id_match(id_match), .programmer_ok(programmer_ok), .flash_ready_irq(flash_ready_irq));
  flash_array_model far_u (.pclk(pclk), .presetn(presetn), .req(array_req.req), .slow(slow),
    .fail_cmd(fail_cmd), .done(array_done), .fail(array_fail));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One APB transfer: note expectation, hold request until pready
  task bus(input logic w, input logic [7:0] a, input logic [31:0] v, input logic er, input logic c,
    input logic [31:0] x);
    int n;
    exq.push_back({c, er, x});
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, v};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Request held until pready is seen high at a rising edge
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      print_verdict;
    end
    {psel, penable} <= 2'b00;
  endtask
  // Bounded wait for the interrupt line
  task wait_irq;
    int n;
    n = 0;
    while (flash_ready_irq !== 1'b1 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 200) begin
      failures++;
      print_verdict;
    end
  endtask
  // Answers against the oldest note; request op captured
  always @(negedge pclk) begin
    if (array_req.req === 1'b1) last_op = array_req.op;
    if (pready === 1'b1 && exq.size() > 0) begin
      e = exq.pop_front();
      chk(32'(pslverr), 32'(e[32]));
      if (e[33]) chk(prdata, e[31:0]);
    end
  end
  initial begin
    seed = 32'hff3f;
    {presetn, psel, penable, pwrite, paddr, pwdata, id_match, fail_cmd, slow} <= '0;
    ops = '{{flash_seq_pkg::OFF_EXCMD, 32'h0000_0101}, {flash_seq_pkg::OFF_EXCMD, 32'h0000_0002},
      {flash_seq_pkg::OFF_CMD, 32'h1}, {flash_seq_pkg::OFF_CMD, 32'h3}, {flash_seq_pkg::OFF_CMD, 32'h4},
      {flash_seq_pkg::OFF_CMD, 32'h6}};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(32'(fetch_allowed), 32'h1);
    for (i = 0; i < 4; i++) bus(0, flash_seq_pkg::OFF_UID0 + 8'(4 * i), 0, 0, 1, UIDB + i);
    bus(1, flash_seq_pkg::OFF_ERR_HI, 32'hFFFF_FFFF, 0, 0, 0);
    bus(0, flash_seq_pkg::OFF_ERR_HI, 0, 0, 1, 32'h0000_0000);
    bus(1, flash_seq_pkg::OFF_EADDR_HI, 32'hFFFF_FFFF, 0, 0, 0);
    bus(0, flash_seq_pkg::OFF_EADDR_HI, 0, 0, 1, 32'h0000_FFFF);
    bus(0, 8'hF0, 0, 0, 1, 32'h0000_0000);
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      bus(1, flash_seq_pkg::OFF_WBUF0 + 8'(4 * i), d, 0, 0, 0);
      bus(0, flash_seq_pkg::OFF_WBUF0 + 8'(4 * i), 0, 0, 1, d);
    end
    bus(1, flash_seq_pkg::OFF_CODE_WAIT, 32'h5, 0, 0, 0);
    bus(1, flash_seq_pkg::OFF_DATA_WAIT, 32'hA, 0, 0, 0);
    @(negedge pclk);
    chk({code_wait, data_wait}, 32'h5A);
    $display("done registers");
    bus(1, flash_seq_pkg::OFF_CMD, 32'h1, 1, 0, 0);
    bus(1, flash_seq_pkg::OFF_MODE, 32'h3, 1, 0, 0);
    bus(1, flash_seq_pkg::OFF_MODE, 32'(flash_seq_pkg::MODE_CODE_PE), 0, 0, 0);
    bus(1, flash_seq_pkg::OFF_CMD, 32'h2, 1, 0, 0);
    bus(1, flash_seq_pkg::OFF_EXCMD, 32'h7, 1, 0, 0);
    bus(1, flash_seq_pkg::OFF_SADDR_HI, 32'h0000_FFFC, 0, 0, 0);
    bus(1, flash_seq_pkg::OFF_CMD, 32'h1, 1, 0, 0);
    bus(1, flash_seq_pkg::OFF_SADDR_HI, 32'h0000_FFFF, 0, 0, 0);
    bus(1, flash_seq_pkg::OFF_SADDR_LO, 32'h0000_8000, 0, 0, 0);
    bus(0, flash_seq_pkg::OFF_IRQ_STAT, 0, 0, 1, 32'h4);
    bus(1, flash_seq_pkg::OFF_IRQ_STAT, 32'h7, 0, 0, 0);
    for (i = 0; i < 6; i++) begin
      bus(1, ops[i][39:32], ops[i][31:0], 0, 0, 0);
      wait_irq;
      if (ops[i][39:32] == flash_seq_pkg::OFF_CMD) chk(32'(last_op), 32'(ops[i][2:0]));
      bus(0, flash_seq_pkg::OFF_IRQ_STAT, 0, 0, 1, 32'h1);
      bus(1, flash_seq_pkg::OFF_IRQ_STAT, 32'h1, 0, 0, 0);
    end
    $display("done commands");
    bus(1, flash_seq_pkg::OFF_IRQ_MASK, 32'h5, 0, 0, 0);
    fail_cmd <= 1'b1;
    bus(1, flash_seq_pkg::OFF_CMD, 32'h1, 0, 0, 0);
    repeat (20) @(negedge pclk);
    chk(32'(flash_ready_irq), 32'h0);
    fail_cmd <= 1'b0;
    bus(1, flash_seq_pkg::OFF_IRQ_MASK, 32'h0, 0, 0, 0);
    wait_irq;
    bus(0, flash_seq_pkg::OFF_ERR_HI, 0, 0, 1, 32'h0000_FFFF);
    bus(1, flash_seq_pkg::OFF_IRQ_STAT, 32'h7, 0, 0, 0);
    @(negedge pclk);
    chk(32'(flash_ready_irq), 32'h0);
    $display("done interrupt");
    bus(1, flash_seq_pkg::OFF_MODE, 32'(flash_seq_pkg::MODE_DATA_PE), 0, 0, 0);
    slow <= 1'b1;
    id_match <= 1'($random(seed)) | 1'b1;
    bus(1, flash_seq_pkg::OFF_CMD, 32'h3, 0, 0, 0);
    chk({31'h0, fetch_allowed}, 32'h1);
    bus(1, flash_seq_pkg::OFF_CMD, 32'h3, 1, 0, 0);
    bus(0, flash_seq_pkg::OFF_IRQ_STAT, 0, 0, 1, 32'h4);
    bus(1, flash_seq_pkg::OFF_IRQ_STAT, 32'h4, 0, 0, 0);
    bus(1, flash_seq_pkg::OFF_STOP, 32'h1, 0, 0, 0);
    wait_irq;
    chk({31'h0, programmer_ok}, 32'h1);
    bus(0, flash_seq_pkg::OFF_IRQ_STAT, 0, 0, 1, 32'h2);
    $display("done background and stop");
    repeat (4) @(posedge pclk);
    print_verdict;
  end
endmodule
